// File: src/emt_pkg.sv
// Shared constants, register map and carrier types of the micro-increment and timestamp block
package emt_pkg;
  // Channels and counter layout
  localparam int NCH = 2;
  localparam int CNT_W = 32;
  localparam int FRAC_W = 8;
  localparam int FRAC_STEPS = 256;
  localparam int PER_W = 24;
  localparam int TS_W = 64;

  // Overrun limit of the signal period, converted to clock cycles
  localparam real CLK_PERIOD_NS = 20.0;
  localparam real OVR_PERIOD_US = 1.34;
  localparam int OVR_CYCLES = int'($floor(OVR_PERIOD_US * 1000.0 / CLK_PERIOD_NS));

  // Register offsets inside one channel block; the channel digit is address bit 6
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STAT = 6'h04;
  localparam logic [5:0] OFF_COUNT = 6'h08;
  localparam logic [5:0] OFF_LIVE = 6'h0C;
  localparam logic [5:0] OFF_TS_FIRST = 6'h10;
  localparam logic [5:0] OFF_TS_END = 6'h30;
  localparam logic [5:0] OFF_LATCH = 6'h30;
  localparam logic [5:0] OFF_LATCH2 = 6'h34;
  localparam int CH_BIT = 6;
  localparam int GLOBAL_BIT = 7;

  // Global registers
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h80;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h84;

  // Timestamp slots and interrupt events per channel
  localparam int TS_CNT = 0;
  localparam int TS_ZERO = 1;
  localparam int TS_LATCH = 2;
  localparam int TS_LATCH2 = 3;
  localparam int EV_ZERO = 0;
  localparam int EV_LATCH = 1;
  localparam int EV_LATCH2 = 2;
  localparam int EV_OVR = 3;
  localparam int EV_N = 4;

  // Evaluation modes of the counter
  typedef enum logic [1:0] {
    EVAL_X4 = 2'h0,
    EVAL_X1 = 2'h1,
    EVAL_X2 = 2'h2
  } emt_eval_t;

  // Per-channel control word
  typedef struct packed {
    logic [21:0] unused;
    logic ts_compact;
    logic ts_en;
    logic gate_neg;
    logic gate_pos;
    logic latch_neg;
    logic latch_pos;
    logic zero_en;
    emt_eval_t eval;
    logic interp_en;
  } emt_ctrl_t;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Encoder tracks and latch inputs of one channel
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic latch;
    logic gate;
  } emt_pins_t;
endpackage

// File: src/emt_top.sv
// Encoder micro-increment interpolation and timestamp capture, two channels, APB registers
// Function
// - Interpolate 8-bit fractions, 256 steps between counted increments.
// - Fraction advances at rate taken from measured increment period.
// - Interpolation only while the channel's interpolation enable bit is set.
// - With interpolation, fraction in low 8 bits, real count above when counting up; counting down, count times 256 minus fraction.
// - Signal period at or below 1.34 us sets the overrun flag.
// - While overrun is set, the 8 fraction bits read as zero.
// - Timestamps are 64 bits, or a compact 32-bit form when selected.
// - Timestamp data can be included or excluded per channel.
// - Each cycle report timestamp of the last counting pulse.
// - Count edge: mode 0 any A/B edge, 1 rising A, 2 any A edge.
// - Zero-pulse rising edge stores counter and its timestamp when enabled.
// - Latch input stores counter and timestamp on enabled rising or falling edge.
// - Gate input stores second counter value and timestamp on enabled edge.
// - Channel digit 0 addresses first channel, 1 the second.
//
// The APB interface to the registers and the address map were chosen for this implementation.
module emt_top #(
  parameter int NCH = emt_pkg::NCH
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Encoder and latch pins
  input wire emt_pkg::emt_pins_t [NCH-1:0] ENC_IN,
  // Synchronized system time and cyclic sample tick
  input wire logic [63:0] SYS_TIME,
  input wire logic CYCLE_TICK,
  // Interrupt
  output logic IRQ
);
  localparam int CW = emt_pkg::CNT_W;
  localparam int PW = emt_pkg::PER_W;
  localparam int NEV = NCH * emt_pkg::EV_N;

  emt_pkg::emt_pins_t [NCH-1:0] pin_s1;
  emt_pkg::emt_pins_t [NCH-1:0] pin_s2;
  emt_pkg::emt_pins_t [NCH-1:0] pin_d;
  emt_pkg::emt_ctrl_t ctrl [NCH];
  logic [CW-1:0] count [NCH];
  logic dir_up [NCH];
  logic [PW-1:0] per_inc [NCH];
  logic [PW-1:0] per_last [NCH];
  logic [PW-1:0] per_a [NCH];
  logic [PW:0] acc [NCH];
  logic [7:0] frac [NCH];
  logic ovr [NCH];
  logic [3:0][63:0] ts_live [NCH];
  logic [3:0][63:0] ts_rep [NCH];
  logic [CW-1:0] latch_val [NCH];
  logic [CW-1:0] latch2_val [NCH];
  logic [CW-1:0] cnt_rep [NCH];
  logic ovr_rep [NCH];
  logic [NEV-1:0] irq_stat;
  logic [NEV-1:0] irq_mask;
  logic [NEV-1:0] ev;
  logic hit [NCH];
  logic up [NCH];
  logic a_rise [NCH];
  logic zero_ev [NCH];
  logic latch_ev [NCH];
  logic gate_ev [NCH];
  logic [CW-1:0] live [NCH];
  logic [31:0] rd;
  logic rd_ok;
  logic apb_wr;

  // Counter value as reported: fraction below the real count when interpolating
  function automatic logic [CW-1:0] live_value(emt_pkg::emt_ctrl_t c, logic [CW-1:0] cnt,
                                              logic [7:0] fr, logic o, logic u);
    logic [CW-1:0] base;
    logic [CW-1:0] f;
    base = {cnt[CW-9:0], 8'h00};
    f = o ? '0 : CW'(fr);
    if (!c.interp_en) begin
      return cnt;
    end
    return u ? (base | f) : (base - f);
  endfunction

  // Reported timestamp, per channel inclusion and compact form
  function automatic logic [63:0] ts_form(emt_pkg::emt_ctrl_t c, logic [63:0] t);
    if (!c.ts_en) begin
      return 64'h0;
    end
    return c.ts_compact ? {32'h0, t[31:0]} : t;
  endfunction

  // Two-flop synchroniser for all pins, plus one delay for edges
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d <= '0;
    end else begin
      pin_s1 <= ENC_IN;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // Edge qualification per evaluation mode and latch enables
  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      a_rise[ch] = pin_s2[ch].a & ~pin_d[ch].a;
      unique case (ctrl[ch].eval)
        emt_pkg::EVAL_X1: begin
          hit[ch] = a_rise[ch];
          up[ch] = ~pin_s2[ch].b;
        end
        emt_pkg::EVAL_X2: begin
          hit[ch] = pin_s2[ch].a ^ pin_d[ch].a;
          up[ch] = pin_s2[ch].a ^ pin_s2[ch].b;
        end
        default: begin
          hit[ch] = (pin_s2[ch].a ^ pin_d[ch].a) | (pin_s2[ch].b ^ pin_d[ch].b);
          up[ch] = pin_s2[ch].a ^ pin_d[ch].b;
        end
      endcase
      zero_ev[ch] = ctrl[ch].zero_en & pin_s2[ch].c & ~pin_d[ch].c;
      latch_ev[ch] = (ctrl[ch].latch_pos & pin_s2[ch].latch & ~pin_d[ch].latch)
                   | (ctrl[ch].latch_neg & ~pin_s2[ch].latch & pin_d[ch].latch);
      gate_ev[ch] = (ctrl[ch].gate_pos & pin_s2[ch].gate & ~pin_d[ch].gate)
                  | (ctrl[ch].gate_neg & ~pin_s2[ch].gate & pin_d[ch].gate);
      live[ch] = live_value(ctrl[ch], count[ch], frac[ch], ovr[ch], dir_up[ch]);
      ev[ch*emt_pkg::EV_N+emt_pkg::EV_ZERO] = zero_ev[ch];
      ev[ch*emt_pkg::EV_N+emt_pkg::EV_LATCH] = latch_ev[ch];
      ev[ch*emt_pkg::EV_N+emt_pkg::EV_LATCH2] = gate_ev[ch];
      ev[ch*emt_pkg::EV_N+emt_pkg::EV_OVR] = a_rise[ch] & ~ovr[ch] && (per_a[ch] < PW'(emt_pkg::OVR_CYCLES));
    end
  end

  // Real count; the base counter is kept minimal here
  always_ff @(posedge MCLK) begin
    for (int ch = 0; ch < NCH; ch++) begin
      if (RST) begin
        count[ch] <= '0;
        dir_up[ch] <= 1'b1;
      end else if (hit[ch]) begin
        count[ch] <= up[ch] ? count[ch] + CW'(1) : count[ch] - CW'(1);
        dir_up[ch] <= up[ch];
      end
    end
  end

  // Period of one increment and phase accumulator for the fraction
  // One fraction step per clock at most: above 50/256 MHz increment rate it lags
  always_ff @(posedge MCLK) begin
    for (int ch = 0; ch < NCH; ch++) begin
      if (RST) begin
        per_inc[ch] <= '0;
        per_last[ch] <= '0;
        acc[ch] <= '0;
        frac[ch] <= '0;
      end else if (hit[ch]) begin
        per_last[ch] <= per_inc[ch] + PW'(1);
        per_inc[ch] <= '0;
        acc[ch] <= '0;
        frac[ch] <= '0;
      end else begin
        if (per_inc[ch] != '1) begin
          per_inc[ch] <= per_inc[ch] + PW'(1);
        end
        // Saturate below the next real increment so the value never runs ahead
        if (per_last[ch] != '0 && frac[ch] != 8'(emt_pkg::FRAC_STEPS - 1)) begin
          if (acc[ch] + (PW+1)'(emt_pkg::FRAC_STEPS) >= {1'b0, per_last[ch]}) begin
            acc[ch] <= acc[ch] + (PW+1)'(emt_pkg::FRAC_STEPS) - {1'b0, per_last[ch]};
            frac[ch] <= frac[ch] + 8'h01;
          end else begin
            acc[ch] <= acc[ch] + (PW+1)'(emt_pkg::FRAC_STEPS);
          end
        end
      end
    end
  end

  // Period on track A, held one below the clock count, so the limit is a strict compare
  always_ff @(posedge MCLK) begin
    for (int ch = 0; ch < NCH; ch++) begin
      if (RST) begin
        per_a[ch] <= '1; // No period known yet: first edge must not flag overrun
        ovr[ch] <= 1'b0;
      end else if (a_rise[ch]) begin
        per_a[ch] <= '0;
        ovr[ch] <= (per_a[ch] < PW'(emt_pkg::OVR_CYCLES));
      end else if (per_a[ch] != '1) begin
        per_a[ch] <= per_a[ch] + PW'(1);
      end
    end
  end

  // Count, zero pulse, latch and gate captures from the common system time
  always_ff @(posedge MCLK) begin
    for (int ch = 0; ch < NCH; ch++) begin
      if (RST) begin
        latch_val[ch] <= '0;
        latch2_val[ch] <= '0;
        ts_live[ch][emt_pkg::TS_CNT] <= '0;
        ts_live[ch][emt_pkg::TS_ZERO] <= '0;
        ts_live[ch][emt_pkg::TS_LATCH] <= '0;
        ts_live[ch][emt_pkg::TS_LATCH2] <= '0;
      end else begin
        if (hit[ch]) begin
          ts_live[ch][emt_pkg::TS_CNT] <= SYS_TIME;
        end
        // Zero pulse and latch share one value; latch wins if both fire together
        if (zero_ev[ch]) begin
          latch_val[ch] <= count[ch];
          ts_live[ch][emt_pkg::TS_ZERO] <= SYS_TIME;
        end
        if (latch_ev[ch]) begin
          latch_val[ch] <= count[ch];
          ts_live[ch][emt_pkg::TS_LATCH] <= SYS_TIME;
        end
        if (gate_ev[ch]) begin
          latch2_val[ch] <= count[ch];
          ts_live[ch][emt_pkg::TS_LATCH2] <= SYS_TIME;
        end
      end
    end
  end

  // Cyclic snapshot keeps reported data constant within one control cycle
  always_ff @(posedge MCLK) begin
    for (int ch = 0; ch < NCH; ch++) begin
      if (RST) begin
        cnt_rep[ch] <= '0;
        ovr_rep[ch] <= 1'b0;
        ts_rep[ch] <= '0;
      end else if (CYCLE_TICK) begin
        cnt_rep[ch] <= live[ch];
        ovr_rep[ch] <= ovr[ch];
        for (int k = 0; k < 4; k++) begin
          ts_rep[ch][k] <= ts_form(ctrl[ch], ts_live[ch][k]);
        end
      end
    end
  end

  // Sticky event bits; a new event wins over a write-one clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      if (apb_wr && PADDR == emt_pkg::ADDR_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~PWDATA[NEV-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (apb_wr && PADDR == emt_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= PWDATA[NEV-1:0];
      end
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

  // Control registers; address bit 6 is the channel digit
  always_ff @(posedge MCLK) begin
    for (int ch = 0; ch < NCH; ch++) begin
      if (RST) begin
        ctrl[ch] <= emt_pkg::CTRL_RST;
      end else if (apb_wr && !PADDR[emt_pkg::GLOBAL_BIT] && PADDR[emt_pkg::CH_BIT] == ch[0]
                   && PADDR[5:0] == emt_pkg::OFF_CTRL) begin
        ctrl[ch] <= PWDATA;
      end
    end
  end

  // Read decode for the addressed word
  always_comb begin
    logic c;
    logic [5:0] off;
    c = PADDR[emt_pkg::CH_BIT];
    off = PADDR[5:0];
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    if (PADDR[emt_pkg::GLOBAL_BIT]) begin
      if (PADDR == emt_pkg::ADDR_IRQ_STAT) begin
        rd = 32'(irq_stat);
      end else if (PADDR == emt_pkg::ADDR_IRQ_MASK) begin
        rd = 32'(irq_mask);
      end else begin
        rd_ok = 1'b0;
      end
    end else if (off >= emt_pkg::OFF_TS_FIRST && off < emt_pkg::OFF_TS_END) begin
      rd = off[2] ? ts_rep[c][off[4:3] - 2'h2][63:32] : ts_rep[c][off[4:3] - 2'h2][31:0];
    end else begin
      unique case (off)
        emt_pkg::OFF_CTRL: rd = ctrl[c];
        emt_pkg::OFF_STAT: rd = {30'h0, ovr_rep[c], ovr[c]};
        emt_pkg::OFF_COUNT: rd = cnt_rep[c];
        emt_pkg::OFF_LIVE: rd = live[c];
        emt_pkg::OFF_LATCH: rd = latch_val[c];
        emt_pkg::OFF_LATCH2: rd = latch2_val[c];
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // APB: read data sampled in the setup cycle, write data in the access cycle, zero wait states
  assign PREADY = PSEL & PENABLE;
  assign apb_wr = PSEL & PENABLE & PWRITE & ~PSLVERR;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= PWRITE ? 32'h0000_0000 : rd;
      PSLVERR <= ~rd_ok;
    end else if (!PSEL) begin
      PSLVERR <= 1'b0;
    end
  end

  // Checks per channel, then on the interrupt
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    ovr_frac_zero_a: assert property (ovr[g] && ctrl[g].interp_en && dir_up[g] |-> live[g][7:0] == 8'h00)
      else $error("fraction not zero during overrun");
    interp_off_a: assert property (!ctrl[g].interp_en |-> live[g] == count[g])
      else $error("fraction present while interpolation disabled");
    count_high_a: assert property (ctrl[g].interp_en && dir_up[g] |-> live[g][31:8] == count[g][23:0])
      else $error("real count not above fraction");
    ovr_set_a: assert property (a_rise[g] |=> ovr[g] == ({1'b0, $past(per_a[g])} + 25'h0000001 <= 25'(emt_pkg::OVR_CYCLES)))
      else $error("overrun not flagged");
    frac_restart_a: assert property (hit[g] |=> frac[g] == 8'h00 && per_last[g] == $past(per_inc[g]) + 24'd1)
      else $error("fraction not restarted at increment");
    x1_edge_a: assert property (ctrl[g].eval == emt_pkg::EVAL_X1 && hit[g] |-> a_rise[g])
      else $error("one-fold counted on wrong edge");
    cnt_stamp_a: assert property (hit[g] |=> ts_live[g][0] == $past(SYS_TIME))
      else $error("count timestamp wrong");
    zero_cap_a: assert property (zero_ev[g] && !latch_ev[g] |=> latch_val[g] == $past(count[g])
                                 && ts_live[g][1] == $past(SYS_TIME))
      else $error("zero pulse capture wrong");
    latch_cap_a: assert property (latch_ev[g] |=> latch_val[g] == $past(count[g]) && ts_live[g][2] == $past(SYS_TIME))
      else $error("latch capture wrong");
    gate_cap_a: assert property (gate_ev[g] |=> latch2_val[g] == $past(count[g]) && ts_live[g][3] == $past(SYS_TIME))
      else $error("gate capture wrong");
    compact_a: assert property (CYCLE_TICK && ctrl[g].ts_compact |=> ts_rep[g][0][63:32] == 32'h0)
      else $error("compact timestamp has high word");
    excluded_a: assert property (CYCLE_TICK && !ctrl[g].ts_en |=> ts_rep[g] == '0)
      else $error("excluded timestamps not zero");
    ovr_seen_c: cover property (ovr[g] && ctrl[g].interp_en);
    gate_seen_c: cover property (gate_ev[g] ##[1:50] CYCLE_TICK);
    frac_run_c: cover property (frac[g] == 8'h80 ##[1:300] hit[g]);
  end
  irq_level_a: assert property (IRQ == |(irq_stat & irq_mask))
    else $error("interrupt level wrong");
  irq_set_a: assert property ((|ev) |=> (irq_stat & $past(ev)) == $past(ev))
    else $error("event not latched in status");
  irq_clear_c: cover property (apb_wr && PADDR == emt_pkg::ADDR_IRQ_STAT && IRQ);
endmodule

// File: test/emt_enc_model.sv
// Encoder track and latch pin source for both channels of the timestamp block
module emt_enc_model (
  // Clock and time reference
  input wire logic clk,
  input wire logic [63:0] sys_time,
  // Pins towards the block
  output emt_pkg::emt_pins_t [1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quadrature phase 0..3 per channel, gray order a/b = 00,10,11,01
  int phase [2];

  // Idle pins low; all pins are plain push-pull levels
  initial begin
    pins = '0;
    phase[0] = 0;
    phase[1] = 0;
  end

  // One quarter-period step after gap clocks; t is the time read at the launching edge
  task automatic step(input int ch, input bit up, input int gap, output logic [63:0] t);
    int p;
    repeat (gap) @(posedge clk);
    p = (phase[ch] + (up ? 1 : 3)) % 4;
    phase[ch] = p;
    pins[ch].a <= (p == 1 || p == 2);
    pins[ch].b <= (p >= 2);
    t = sys_time;
  endtask

  // Level change on zero pulse (0), latch (1) or gate (2) after gap clocks
  task automatic set_pin(input int ch, input int which, input bit v, input int gap, output logic [63:0] t);
    repeat (gap) @(posedge clk);
    case (which)
      0: pins[ch].c <= v;
      1: pins[ch].latch <= v;
      default: pins[ch].gate <= v;
    endcase
    t = sys_time;
  endtask
endmodule

// File: test/emt_top_tb.sv
// Self-checking bench for the two-channel micro-increment and timestamp block
module emt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Pin pipeline: the capture holds the time three edges after the pin launch
  localparam int TS_LAG = 3;
  logic MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CYCLE_TICK, IRQ, err, up;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [63:0] SYS_TIME, t, t_rise, t_fall;
  logic [63:0] t_cnt [2];
  emt_pkg::emt_pins_t [1:0] pins;
  integer seed = 32'hd993;
  int n_fail, n_tests, cyc, slot;
  int cnt [2];
  int ph [2];

  emt_top #(.NCH(2)) dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ENC_IN(pins), .SYS_TIME(SYS_TIME), .CYCLE_TICK(CYCLE_TICK), .IRQ(IRQ));
  emt_enc_model enc (.clk(MCLK), .sys_time(SYS_TIME), .pins(pins));

  // 50 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // System time starts near a 32-bit rollover so the high word is exercised
  always @(posedge MCLK) SYS_TIME <= SYS_TIME + 64'h1;

  // Hang guard, well above the expected run length
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    int k;
    k = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 20) n_fail++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, err);
    chk(nm, e, rd);
  endtask

  // Channel digit selects the 64-byte register block
  function automatic logic [7:0] addr(int c, logic [5:0] off);
    return {1'b0, 1'(c), off};
  endfunction

  task automatic chk_ts(input int c, input int s, input logic [63:0] e);
    rdc("ts low", addr(c, emt_pkg::OFF_TS_FIRST + 6'(8 * s)), e[31:0]);
    rdc("ts high", addr(c, emt_pkg::OFF_TS_FIRST + 6'(8 * s + 4)), e[63:32]);
  endtask

  // Count change of one quadrature step in evaluation mode m
  function automatic int delta(int m, int p0, int p1);
    logic a0, a1, b1;
    a0 = (p0 == 1 || p0 == 2);
    a1 = (p1 == 1 || p1 == 2);
    b1 = (p1 >= 2);
    if (m == 1) return (!a0 && a1) ? (b1 ? -1 : 1) : 0;
    if (m == 2) return (a0 != a1) ? ((a1 ^ b1) ? 1 : -1) : 0;
    return ((p0 + 1) % 4 == p1) ? 1 : -1;
  endfunction

  // Steps on the pins and the reference count and count timestamp beside them
  task automatic stepn(input int c, input int k, input bit u, input int gap, input int m);
    int p, d;
    repeat (k) begin
      enc.step(c, u, gap, t);
      p = (ph[c] + (u ? 1 : 3)) % 4;
      d = delta(m, ph[c], p);
      ph[c] = p;
      cnt[c] += d;
      if (d != 0) t_cnt[c] = t + TS_LAG;
    end
  endtask

  // Pipeline settles, then a one-cycle end-of-cycle tick
  task automatic tick();
    repeat (4) @(posedge MCLK);
    CYCLE_TICK <= 1'b1;
    @(posedge MCLK);
    CYCLE_TICK <= 1'b0;
  endtask

  initial begin
    {RST, PSEL, PENABLE, PWRITE, CYCLE_TICK} = 5'h10;
    {PADDR, PWDATA} = '0;
    SYS_TIME = 64'h0000_0001_FFFF_E000;
    {cnt[0], cnt[1], ph[0], ph[1], n_fail, n_tests, cyc} = '0;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    rdc("ctrl reset", addr(0, emt_pkg::OFF_CTRL), 32'h0);
    rdc("mask reset", emt_pkg::ADDR_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h88, 32'h0, rd, err);
    chk1("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h0, rd);
    for (int c = 0; c < 2; c++) begin
      // Every evaluation mode, random burst length and direction
      for (int m = 0; m < 3; m++) begin
        up = 1'($random(seed));
        wr(addr(c, emt_pkg::OFF_CTRL), 32'h100 | (m << 1));
        stepn(c, 4 + ($random(seed) & 3), up, 20 + ($random(seed) & 15), m);
        tick();
        rdc("count", addr(c, emt_pkg::OFF_COUNT), cnt[c]);
        chk_ts(c, emt_pkg::TS_CNT, t_cnt[c]);
      end
      // Zero pulse, latch rise/fall, gate rise/fall, one enable at a time
      for (int k = 0; k < 5; k++) begin
        slot = (k == 0) ? 1 : ((k < 3) ? 2 : 3);
        wr(addr(c, emt_pkg::OFF_CTRL), 32'h100 | (32'h8 << k));
        stepn(c, 2, 1'b1, 20, 0);
        enc.set_pin(c, slot - 1, 1'b1, 10, t_rise);
        enc.set_pin(c, slot - 1, 1'b0, 10, t_fall);
        tick();
        rdc("latch value", addr(c, (k < 3) ? emt_pkg::OFF_LATCH : emt_pkg::OFF_LATCH2), cnt[c]);
        chk_ts(c, slot, ((k == 2 || k == 4) ? t_fall : t_rise) + TS_LAG);
        rdc("capture event", emt_pkg::ADDR_IRQ_STAT, 32'h1 << (c * 4 + slot - 1));
        wr(emt_pkg::ADDR_IRQ_STAT, 32'hFFFF_FFFF);
      end
    end
    // Compact form, then timestamps left out
    wr(addr(0, emt_pkg::OFF_CTRL), 32'h300);
    stepn(0, 4, 1'b1, 20, 0);
    tick();
    chk_ts(0, emt_pkg::TS_CNT, {32'h0, t_cnt[0][31:0]});
    wr(addr(0, emt_pkg::OFF_CTRL), 32'h0);
    tick();
    chk_ts(0, emt_pkg::TS_CNT, 64'h0);
    // Interrupt raised, masked, cleared
    wr(emt_pkg::ADDR_IRQ_MASK, 32'h20);
    wr(addr(1, emt_pkg::OFF_CTRL), 32'h110);
    enc.set_pin(1, 1, 1'b1, 2, t_rise);
    repeat (6) @(posedge MCLK);
    @(negedge MCLK);
    chk1("irq raised", 1'b1, IRQ);
    wr(emt_pkg::ADDR_IRQ_MASK, 32'h0);
    @(negedge MCLK);
    chk1("irq masked", 1'b0, IRQ);
    wr(emt_pkg::ADDR_IRQ_MASK, 32'h20);
    @(negedge MCLK);
    chk1("irq unmasked", 1'b1, IRQ);
    wr(emt_pkg::ADDR_IRQ_STAT, 32'h20);
    @(negedge MCLK);
    chk1("irq cleared", 1'b0, IRQ);
    // Interpolation: slow motion moves the fraction, fast motion overruns
    wr(addr(0, emt_pkg::OFF_CTRL), 32'h101);
    stepn(0, 4, 1'b1, 100, 0);
    repeat (50) @(posedge MCLK);
    apb(1'b0, addr(0, emt_pkg::OFF_LIVE), 32'h0, rd, err);
    chk("live count", {8'h0, 24'(cnt[0])}, {8'h0, rd[31:8]});
    chk1("fraction moving", 1'b1, |rd[7:0]);
    stepn(0, 8, 1'b1, 10, 0);
    tick();
    rdc("overrun status", addr(0, emt_pkg::OFF_STAT), 32'h3);
    rdc("overrun count", addr(0, emt_pkg::OFF_COUNT), {24'(cnt[0]), 8'h00});
    rdc("overrun event", emt_pkg::ADDR_IRQ_STAT, 32'h8);
    stepn(0, 4, 1'b1, 100, 0);
    tick();
    rdc("overrun gone", addr(0, emt_pkg::OFF_STAT), 32'h0);
    // Period of 68 clocks lies just above the overrun limit of 67
    stepn(0, 8, 1'b1, 17, 0);
    tick();
    rdc("overrun boundary", addr(0, emt_pkg::OFF_STAT), 32'h0);
    final_report();
  end
endmodule
